//--- src/snoop_pkg.sv
/*
  constants and carriers for the coherent snoop issue block.
  assumes one interconnect clock; transaction and snoop codes are internal encodings.
*/
// Notes on behaviour
// - the block itself issues every snoop that a transaction needs, and cached masters never snoop each other.
// - non-snooping reads, writes, write-backs, write-cleans, write-evicts and evicts complete with no snoop at all.
// - the four sharing reads snoop possible holders until data arrives, a response shows was-unique, or all are done.
// - a clean-shared snoops possible holders until a dirty copy arrives, was-unique is seen, or all are done.
// - the unique and invalidating requests snoop possible holders until was-unique is seen or all are done.
// - the originating master is never snooped for its own transaction.
// - unique and invalidating requests leave snooped caches invalid, and a read-once asks no state change.
// - sharing reads leave snooped caches shared or invalid, and clean-shared leaves them clean or invalid.
// - the preferred snoop is the same-named one for reads and clean-shared, clean-invalid or make-invalid otherwise.
// - read-unique or clean-invalid may stand in for any snoop, with the narrower substitutes as allowed per type.
// - when holders are not snooped all at once, further snoop types may serve the unique and clean-invalid group.
// - holders may be snooped one after another instead of all together.
// - different holders may receive different snoop types for one transaction.
// - in sequential snooping of the unique and clean-invalid group, make-invalid may follow a pass-dirty response.
// - no snoop goes to a master for a line while that master still owes an acknowledge for it; the block checks this only when it picks the target.
package snoop_pkg;
  localparam int NUM_MASTERS = 4;
  localparam int ADDR_W = 32;
  localparam int LINE_LSB = 6;
  localparam int RESP_WAS_UNIQUE = 4;
  localparam int RESP_IS_SHARED = 3;
  localparam int RESP_PASS_DIRTY = 2;
  localparam int RESP_ERROR = 1;
  localparam int RESP_DATA = 0;
  localparam logic [NUM_MASTERS-1:0] DOMAIN_MEMBERS = 4'hf;

  typedef enum logic [4:0] {
    TR_READ_NO_SNOOP = 5'h00, TR_READ_ONCE = 5'h01, TR_READ_CLEAN = 5'h02,
    TR_READ_NSD = 5'h03, TR_READ_SHARED = 5'h04, TR_READ_UNIQUE = 5'h05,
    TR_CLEAN_UNIQUE = 5'h06, TR_MAKE_UNIQUE = 5'h07, TR_CLEAN_SHARED = 5'h08,
    TR_CLEAN_INVALID = 5'h09, TR_MAKE_INVALID = 5'h0a, TR_WRITE_NO_SNOOP = 5'h0b,
    TR_WRITE_UNIQUE = 5'h0c, TR_WRITE_LINE_UNIQUE = 5'h0d, TR_WRITE_BACK = 5'h0e,
    TR_WRITE_CLEAN = 5'h0f, TR_WRITE_EVICT = 5'h10, TR_EVICT = 5'h11
  } trans_type;

  typedef enum logic [3:0] {
    SN_READ_ONCE = 4'h0, SN_READ_SHARED = 4'h1, SN_READ_CLEAN = 4'h2,
    SN_READ_NSD = 4'h3, SN_READ_UNIQUE = 4'h7, SN_CLEAN_SHARED = 4'h8,
    SN_CLEAN_INVALID = 4'h9, SN_MAKE_INVALID = 4'hd
  } snoop_type;

  // stop policy per transaction class
  typedef enum logic [1:0] {
    STOP_NONE = 2'h0, STOP_ON_DATA = 2'h1, STOP_ON_DIRTY = 2'h2, STOP_UNIQUE_ONLY = 2'h3
  } stop_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    trans_type kind;
    logic [1:0] origin;
  } req_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    snoop_type kind;
  } snoop_req_type;
endpackage

//--- src/coherent_snoop_issue.sv
/*
  sequential snoop issue engine: takes one initiating request at a time, snoops
  possible holders one by one and reports when snooping is done.
  assumes requesters hold req until accepted and cached masters answer each snoop once.
  the engine state is kept in four groups: control, response bits, snoop channel, handshake.
*/
`timescale 1ns/10ps
module coherent_snoop_issue #(
  parameter int NUM_MASTERS = snoop_pkg::NUM_MASTERS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // initiating request
  input wire logic req_valid,
  input wire snoop_pkg::req_type req,
  output logic req_ready,
  // snoop filter narrowing, one bit per master
  input wire logic [NUM_MASTERS-1:0] filter_hit,
  // outstanding acknowledge per master and its line
  input wire logic [NUM_MASTERS-1:0] ack_pending,
  input wire logic [NUM_MASTERS*snoop_pkg::ADDR_W-1:0] ack_addr,
  // snoop address channel, one target at a time
  output logic snp_valid,
  output logic [NUM_MASTERS-1:0] snp_target,
  output snoop_pkg::snoop_req_type snp,
  input wire logic snp_ready,
  // snoop response from the target
  input wire logic resp_valid,
  input wire logic [4:0] resp,
  // completion of snooping
  output logic done_valid,
  output logic done_data,
  output logic done_dirty,
  output logic done_unique
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_PICK = 2'b01, ST_ISSUE = 2'b11, ST_WAIT = 2'b10
  } state_type;

  // stop policy by transaction class
  function automatic snoop_pkg::stop_type stop_of(input snoop_pkg::trans_type t);
    case (t)
      snoop_pkg::TR_READ_ONCE, snoop_pkg::TR_READ_CLEAN, snoop_pkg::TR_READ_NSD,
      snoop_pkg::TR_READ_SHARED: stop_of = snoop_pkg::STOP_ON_DATA;
      snoop_pkg::TR_CLEAN_SHARED: stop_of = snoop_pkg::STOP_ON_DIRTY;
      snoop_pkg::TR_READ_UNIQUE, snoop_pkg::TR_CLEAN_UNIQUE, snoop_pkg::TR_MAKE_UNIQUE,
      snoop_pkg::TR_CLEAN_INVALID, snoop_pkg::TR_MAKE_INVALID, snoop_pkg::TR_WRITE_UNIQUE,
      snoop_pkg::TR_WRITE_LINE_UNIQUE: stop_of = snoop_pkg::STOP_UNIQUE_ONLY;
      default: stop_of = snoop_pkg::STOP_NONE;
    endcase
  endfunction

  // preferred snoop; make-invalid after pass-dirty in the unique group
  function automatic snoop_pkg::snoop_type snoop_of(input snoop_pkg::trans_type t, input logic dirty_seen);
    case (t)
      snoop_pkg::TR_READ_ONCE: snoop_of = snoop_pkg::SN_READ_ONCE;
      snoop_pkg::TR_READ_CLEAN: snoop_of = snoop_pkg::SN_READ_CLEAN;
      snoop_pkg::TR_READ_NSD: snoop_of = snoop_pkg::SN_READ_NSD;
      snoop_pkg::TR_READ_SHARED: snoop_of = snoop_pkg::SN_READ_SHARED;
      snoop_pkg::TR_CLEAN_SHARED: snoop_of = snoop_pkg::SN_CLEAN_SHARED;
      snoop_pkg::TR_READ_UNIQUE: snoop_of = dirty_seen ? snoop_pkg::SN_MAKE_INVALID
                                                       : snoop_pkg::SN_READ_UNIQUE;
      snoop_pkg::TR_CLEAN_UNIQUE, snoop_pkg::TR_CLEAN_INVALID, snoop_pkg::TR_WRITE_UNIQUE:
        snoop_of = dirty_seen ? snoop_pkg::SN_MAKE_INVALID : snoop_pkg::SN_CLEAN_INVALID;
      snoop_pkg::TR_MAKE_UNIQUE, snoop_pkg::TR_MAKE_INVALID, snoop_pkg::TR_WRITE_LINE_UNIQUE:
        snoop_of = snoop_pkg::SN_MAKE_INVALID;
      default: snoop_of = snoop_pkg::SN_CLEAN_INVALID;
    endcase
  endfunction

  // lowest set bit as one-hot
  function automatic logic [NUM_MASTERS-1:0] first_of(input logic [NUM_MASTERS-1:0] v);
    first_of = v & (~v + 1'b1);
  endfunction

  // reset release
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  state_type state_q, state_d;
  snoop_pkg::req_type cur_q, cur_d;
  logic [NUM_MASTERS-1:0] left_q, left_d;
  logic [NUM_MASTERS-1:0] tgt_q, tgt_d;
  logic dirty_q, dirty_d;
  logic data_q, data_d;
  logic uniq_q, uniq_d;
  logic ready_q, ready_d;
  logic sv_q, sv_d;
  snoop_pkg::snoop_req_type snp_q, snp_d;
  logic dv_q, dv_d;
  logic [NUM_MASTERS-1:0] blocked;
  logic [NUM_MASTERS-1:0] eligible;
  logic stop_now;

  // masters that still owe an acknowledge for this line
  always_comb begin
    blocked = '0;
    for (int i = 0; i < NUM_MASTERS; i++) begin
      blocked[i] = ack_pending[i] &&
        (ack_addr[i*snoop_pkg::ADDR_W+snoop_pkg::LINE_LSB +: snoop_pkg::ADDR_W-snoop_pkg::LINE_LSB] ==
         cur_q.addr[snoop_pkg::ADDR_W-1:snoop_pkg::LINE_LSB]);
    end
  end

  assign eligible = left_q & ~blocked;

  // stop decision on a response
  always_comb begin
    case (stop_of(cur_q.kind))
      snoop_pkg::STOP_ON_DATA: stop_now = resp[snoop_pkg::RESP_WAS_UNIQUE] || resp[snoop_pkg::RESP_DATA];
      snoop_pkg::STOP_ON_DIRTY: stop_now = resp[snoop_pkg::RESP_WAS_UNIQUE] ||
                                           resp[snoop_pkg::RESP_PASS_DIRTY];
      snoop_pkg::STOP_UNIQUE_ONLY: stop_now = resp[snoop_pkg::RESP_WAS_UNIQUE];
      default: stop_now = 1'b1;
    endcase
  end

  // control next state: phase, request held, holders still to snoop
  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    left_d = left_q;
    case (state_q)
      ST_IDLE: begin
        if (req_valid && ready_q) begin
          cur_d = req;
          // holders from membership and filter, minus origin
          left_d = snoop_pkg::DOMAIN_MEMBERS[NUM_MASTERS-1:0] & filter_hit &
                   ~(NUM_MASTERS'(1) << req.origin);
          if (stop_of(req.kind) == snoop_pkg::STOP_NONE) begin
            left_d = '0;
          end
          state_d = ST_PICK;
        end
      end
      ST_PICK: begin
        if (left_q == '0) begin
          state_d = ST_IDLE; // all possible holders covered
        end else if (eligible != '0) begin
          state_d = ST_ISSUE; // blocked holders are skipped; the engine stays here only while every holder left is blocked
        end
      end
      ST_ISSUE: begin
        if (snp_ready) begin
          left_d = left_q & ~tgt_q;
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (resp_valid) begin
          if (stop_now) begin
            left_d = '0;
          end
          state_d = ST_PICK;
        end
      end
      default: begin
        state_d = ST_IDLE;
        left_d = '0;
      end
    endcase
  end

  // control registers
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      left_q <= '0;
    end else begin
      state_q <= state_d;
      cur_q <= cur_d;
      left_q <= left_d;
    end
  end

  // response bits gathered over the snoops, cleared on a new request
  always_comb begin
    dirty_d = dirty_q;
    data_d = data_q;
    uniq_d = uniq_q;
    case (state_q)
      ST_IDLE: begin
        if (req_valid && ready_q) begin
          dirty_d = 1'b0;
          data_d = 1'b0;
          uniq_d = 1'b0;
        end
      end
      ST_WAIT: begin
        if (resp_valid) begin
          dirty_d = dirty_q | resp[snoop_pkg::RESP_PASS_DIRTY];
          data_d = data_q | resp[snoop_pkg::RESP_DATA];
          uniq_d = uniq_q | resp[snoop_pkg::RESP_WAS_UNIQUE];
        end
      end
      default: begin
        dirty_d = dirty_q; // answers outside a wait are ignored
      end
    endcase
  end

  // response bit registers, held until the next request is taken
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      dirty_q <= 1'b0;
      data_q <= 1'b0;
      uniq_q <= 1'b0;
    end else begin
      dirty_q <= dirty_d;
      data_q <= data_d;
      uniq_q <= uniq_d;
    end
  end

  // snoop channel next state: one target, its snoop and valid
  always_comb begin
    tgt_d = tgt_q;
    sv_d = sv_q;
    snp_d = snp_q;
    case (state_q)
      ST_IDLE: begin
        sv_d = 1'b0;
      end
      ST_PICK: begin
        if (eligible != '0) begin
          tgt_d = first_of(eligible);
          snp_d.addr = cur_q.addr;
          snp_d.kind = snoop_of(cur_q.kind, dirty_q);
          sv_d = 1'b1;
        end
      end
      ST_ISSUE: begin
        if (snp_ready) begin
          sv_d = 1'b0; // offer stands until taken
        end
      end
      default: begin
        sv_d = sv_q;
      end
    endcase
  end

  // snoop channel registers
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      tgt_q <= '0;
      sv_q <= 1'b0;
      snp_q <= '0;
    end else begin
      tgt_q <= tgt_d;
      sv_q <= sv_d;
      snp_q <= snp_d;
    end
  end

  // request ready and done pulse, each high in one phase only
  always_comb begin
    ready_d = 1'b0;
    dv_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        ready_d = 1'b1;
        if (req_valid && ready_q) begin
          ready_d = 1'b0; // drops once a request is taken
        end
      end
      ST_PICK: begin
        dv_d = (left_q == '0); // all possible holders covered
      end
      default: begin
        ready_d = 1'b0;
      end
    endcase
  end

  // ready and done registers
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ready_q <= 1'b0;
      dv_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
      dv_q <= dv_d;
    end
  end

  // outputs straight from flops
  assign req_ready = ready_q;
  assign snp_valid = sv_q;
  assign snp_target = tgt_q;
  assign snp = snp_q;
  assign done_valid = dv_q;
  assign done_data = data_q;
  assign done_dirty = dirty_q;
  assign done_unique = uniq_q;
endmodule

//--- bench/snoop_issue_checker_properties.sv
/* port checker for the snoop issue block.
   bound into every instance of the block at the foot of this file. */
`timescale 1ns/10ps
module snoop_issue_checker #(
  parameter int NUM_MASTERS = 4
) (
  // watched ports
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire snoop_pkg::req_type req,
  input wire logic req_ready,
  input wire logic snp_valid,
  input wire logic [NUM_MASTERS-1:0] snp_target,
  input wire snoop_pkg::snoop_req_type snp,
  input wire logic snp_ready,
  input wire logic resp_valid,
  input wire logic [4:0] resp,
  input wire logic done_valid,
  input wire logic done_dirty,
  input wire logic done_unique
);
  logic take;
  snoop_pkg::req_type cur_d, cur_q;
  // hold the request being served
  assign take = req_valid && req_ready;
  always_comb cur_d = take ? req : cur_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) cur_q <= '0;
    else cur_q <= cur_d;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_no_snoop;
    take && req.kind inside {5'h00, 5'h0b, 5'h0e, 5'h0f, 5'h10, 5'h11} |=> !snp_valid [*2] ##0 done_valid;
  endproperty
  a_no_snoop: assert property (p_no_snoop) else $error("snoop for a no-snoop request");
  property p_not_origin; snp_valid |-> !snp_target[cur_q.origin]; endproperty
  a_not_origin: assert property (p_not_origin) else $error("origin snooped");
  property p_onehot; snp_valid |-> $onehot(snp_target); endproperty
  a_onehot: assert property (p_onehot) else $error("snoop target not one-hot");
  property p_hold; snp_valid && !snp_ready |=> snp_valid && $stable(snp) && $stable(snp_target); endproperty
  a_hold: assert property (p_hold) else $error("snoop dropped before taken");
  property p_unique_stop; resp_valid && resp[4] |-> ##2 done_valid && done_unique; endproperty
  a_unique_stop: assert property (p_unique_stop) else $error("no stop on was-unique");
  property p_dirty_stop; resp_valid && resp[2] && cur_q.kind == 5'h08 |-> ##2 done_valid && done_dirty; endproperty
  a_dirty_stop: assert property (p_dirty_stop) else $error("no stop on dirty copy");
  property p_data_stop; resp_valid && resp[0] && cur_q.kind inside {[5'h01:5'h04]} |-> ##2 done_valid; endproperty
  a_data_stop: assert property (p_data_stop) else $error("no stop on line copy");
  property p_inval_kind;
    snp_valid && cur_q.kind inside {5'h05, 5'h06, 5'h07, 5'h09, 5'h0a, 5'h0c, 5'h0d} |-> snp.kind inside {4'h7, 4'h9, 4'hd};
  endproperty
  a_inval_kind: assert property (p_inval_kind) else $error("snoop leaves line valid");
  property p_share_kind; snp_valid && cur_q.kind inside {[5'h02:5'h04]} |-> snp.kind inside {[4'h1:4'h3], 4'h7, 4'h9}; endproperty
  a_share_kind: assert property (p_share_kind) else $error("snoop kind not sharing");
endmodule
bind coherent_snoop_issue snoop_issue_checker #(.NUM_MASTERS(NUM_MASTERS)) i_snoop_issue_checker (.mclk, .rst_b,
  .req_valid, .req, .req_ready, .snp_valid, .snp_target, .snp, .snp_ready, .resp_valid, .resp, .done_valid,
  .done_dirty, .done_unique);

//--- bench/snoop_master_model.sv
/* cached masters answering snoops, one 5-bit response per master.
   slow stretches both the accept and the reply. */
`timescale 1ns/10ps
module snoop_master_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // snoop channel
  input wire logic snp_valid,
  input wire logic [3:0] snp_target,
  output logic snp_ready,
  output logic resp_valid,
  output logic [4:0] resp,
  // behaviour set by the bench
  input wire logic [19:0] answers,
  input wire logic slow
);
  int cnt, wait_n;
  logic [4:0] pend;
  // accept after a delay, reply later with that master's bits
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      snp_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp <= 5'h00;
      cnt <= 0;
      wait_n <= 0;
    end else begin
      resp_valid <= 1'b0;
      resp <= ~resp; // answer toggles between replies, so the old one shows every other cycle
      if (snp_valid && snp_ready) begin
        snp_ready <= 1'b0;
        cnt <= 0;
        wait_n <= slow ? 4 : 1;
        for (int i = 0; i < 4; i++) if (snp_target[i]) pend <= answers[i*5+:5];
      end else if (snp_valid) begin
        cnt <= cnt + 1;
        snp_ready <= cnt >= (slow ? 2 : 0);
      end
      if (wait_n == 1) begin
        resp_valid <= 1'b1;
        resp <= pend;
      end
      if (wait_n > 0) wait_n <= wait_n - 1;
    end
  end
endmodule

//--- bench/test_coherent_snoop_issue.sv
/* self-checking bench for coherent_snoop_issue.
   needs the package, the design, the checker and the master model. */
`timescale 1ns/10ps
module test_coherent_snoop_issue;
  logic mclk, rst_b, req_valid, req_ready, snp_valid, snp_ready, resp_valid;
  logic done_valid, done_data, done_dirty, done_unique, slow, blk, aok;
  snoop_pkg::req_type req;
  snoop_pkg::snoop_req_type snp;
  logic [3:0] filter_hit, ack_pending, snp_target, mask, k_first, k_last;
  logic [127:0] ack_addr;
  logic [19:0] answers;
  logic [4:0] resp;
  int errors, checks_done, cyc, n;
  coherent_snoop_issue i_coherent_snoop_issue (.mclk, .rst_b, .req_valid, .req, .req_ready, .filter_hit,
    .ack_pending, .ack_addr, .snp_valid, .snp_target, .snp, .snp_ready, .resp_valid, .resp, .done_valid,
    .done_data, .done_dirty, .done_unique);
  snoop_master_model i_snoop_master_model (.mclk, .rst_b, .snp_valid, .snp_target, .snp_ready, .resp_valid,
    .resp, .answers, .slow);
  // clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // cycle limit and record of taken snoops
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
    if (snp_valid && snp_ready) begin
      mask = mask | snp_target;
      blk = blk | (|(snp_target & ack_pending));
      aok = aok & (snp.addr === 32'h0000_1000);
      if (n == 0) k_first = snp.kind;
      k_last = snp.kind;
      n++;
    end
  end
  task automatic results;
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one request start to finish, then the required gap
  task automatic run(input logic [4:0] k, input logic [1:0] o, input logic [19:0] ans, input logic s,
                     input logic [3:0] f);
    int t;
    @(posedge mclk);
    answers <= ans;
    slow <= s;
    filter_hit <= f;
    mask = 4'h0;
    blk = 1'b0;
    aok = 1'b1;
    n = 0;
    req_valid <= 1'b1;
    req <= '{32'h0000_1000, snoop_pkg::trans_type'(k), o};
    do @(posedge mclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (done_valid !== 1'b1 && t < 300);
    chk("done in time", 4'h1, {3'h0, t < 300});
    chk("snoop addr", 4'h1, {3'h0, aok});
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_no_snoop;
    logic [4:0] ks [6] = '{5'h00, 5'h0b, 5'h0e, 5'h0f, 5'h10, 5'h11};
    foreach (ks[i]) begin
      run(ks[i], 2'h0, 20'h00400, 1'b0, 4'hf);
      chk("no-snoop mask", 4'h0, mask);
    end
  endtask
  task automatic t_reads;
    logic [3:0] pref [4] = '{4'h0, 4'h2, 4'h3, 4'h1};
    for (int i = 0; i < 4; i++) begin
      run(5'(i + 1), 2'h0, 20'h00400, 1'b0, 4'hf);
      chk("read mask", 4'h6, mask);
      chk("read kind", pref[i], k_first);
      chk("read data", 4'h1, {3'h0, done_data});
    end
  endtask
  task automatic t_all_slow;
    run(5'h04, 2'h1, 20'h00000, 1'b1, 4'hf);
    chk("all mask", 4'hd, mask);
    chk("all count", 4'h3, n[3:0]);
    chk("all data", 4'h0, {3'h0, done_data});
  endtask
  task automatic t_clean_shared;
    run(5'h08, 2'h0, 20'h00480, 1'b0, 4'hf);
    chk("clean mask", 4'h2, mask);
    chk("clean kind", 4'h8, k_first);
    chk("clean dirty", 4'h1, {3'h0, done_dirty});
  endtask
  task automatic t_unique;
    logic [4:0] ks [7] = '{5'h05, 5'h06, 5'h07, 5'h09, 5'h0a, 5'h0c, 5'h0d};
    logic [3:0] pref [7] = '{4'h7, 4'h9, 4'hd, 4'h9, 4'hd, 4'h9, 4'hd};
    foreach (ks[i]) begin
      run(ks[i], 2'h3, 20'h00205, 1'b0, 4'hf);
      chk("unique mask", 4'h3, mask);
      chk("unique kind", pref[i], k_first);
      chk("after dirty", 4'hd, k_last);
      chk("unique seen", 4'h1, {3'h0, done_unique});
    end
  endtask
  task automatic t_filter_ack;
    run(5'h04, 2'h0, 20'h00000, 1'b0, 4'h4);
    chk("filter mask", 4'h4, mask);
    ack_pending <= 4'h2;
    fork
      run(5'h04, 2'h0, 20'h00000, 1'b0, 4'hf);
      begin
        repeat (30) @(posedge mclk);
        ack_pending <= 4'h0;
      end
    join
    chk("ack blocked", 4'h0, {3'h0, blk});
    chk("ack mask", 4'he, mask);
  endtask
  // reset, then every scenario
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    filter_hit = 4'hf;
    ack_pending = 4'h0;
    ack_addr = {4{32'h0000_1000}};
    answers = 20'h0;
    slow = 1'b0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    t_no_snoop;
    t_reads;
    t_all_slow;
    t_clean_shared;
    t_unique;
    t_filter_ack;
    results;
  end
endmodule
